// file: rtl/mbp_top.sv
`timescale 1ns/1ps
// How it works
// - address strobe marks address on low bus
// - strobe every five clocks unless low power
// - two ports, one direction bit per line
// - direction bit one is output, zero input
// - output lines drive the held latch value
// - reset clears all direction bits
// - reset keeps output latches untouched
// - upper address stands whole bus cycle
// - address phase, then data phase on bus
// - bus data direction follows read/write line
// - write to input line only loads latch
// - write to output line drives at once
// - input line reads the pin level
// - output line reads the latch
// - decode full 8192-byte address space
// - low 128 bytes internal, unused holes read zero
// - internal reads ignore the external bus
// - 64-byte stack, pointer starts at 7f
// - read/write line high read, low write
// - data strobe on every transfer
module mbp_top
   import mbp_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_sys_rst,
   // Core request
   input  wire logic              i_req_valid,
   input  wire logic              i_req_write,
   input  wire logic [ADDR_W-1:0] i_req_addr,
   input  wire logic [7:0]        i_req_wdata,
   output logic                   o_req_ready,
   // Core answer
   output logic                   o_rsp_valid,
   output logic      [7:0]        o_rsp_rdata,
   // Wait or stop mode
   input  wire logic              i_low_power,
   // Stack pointer control
   input  wire logic              i_sp_push,
   input  wire logic              i_sp_pop,
   input  wire logic              i_sp_reset,
   output logic      [ADDR_W-1:0] o_stack_addr,
   // Multiplexed bus
   output logic                   o_address_latch_strobe,
   output logic                   o_data_transfer_strobe,
   output logic                   o_read_not_write,
   output logic      [4:0]        o_upper_address_lines,
   input  wire logic [7:0]        i_muxed_address_data_lines_in,
   output logic      [7:0]        o_muxed_address_data_lines_out,
   output logic                   o_muxed_address_data_lines_oe_n,
   // Port A
   input  wire logic [7:0]        i_port_a_lines_in,
   output logic      [7:0]        o_port_a_lines_out,
   output logic      [7:0]        o_port_a_lines_oe_n,
   // Port B
   input  wire logic [7:0]        i_port_b_lines_in,
   output logic      [7:0]        o_port_b_lines_out,
   output logic      [7:0]        o_port_b_lines_oe_n
);

   ////////////////////////////////////////////////////////////////////////
   // Decoding

   function automatic logic is_internal(input logic [ADDR_W-1:0] a);
      return a < 13'(INT_LIMIT);
   endfunction

   function automatic logic is_ram(input logic [ADDR_W-1:0] a);
      return is_internal(a) && (a >= RAM_BASE);
   endfunction

   function automatic logic [RAM_AW-1:0] ram_index(
      input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - RAM_BASE;
      return d[RAM_AW-1:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      mbp_phase_t        phase;
      logic              busy;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              as_q;
      logic              ds_q;
      logic              rw_q;
      logic [7:0]        bus_out;
      logic              bus_drive;
      logic [7:0]        dir_a;
      logic [7:0]        dir_b;
      logic [7:0]        lat_a;
      logic [7:0]        lat_b;
      logic [7:0]        pin_a;
      logic [7:0]        pin_b;
      logic [7:0]        tmr_data;
      logic [7:0]        tmr_ctrl;
      logic [5:0]        sp;
      logic              rsp_valid;
      logic [7:0]        rdata;
   } mbp_state_t;

   mbp_state_t st_reg;
   mbp_state_t st_next;

   logic [7:0] port_a_level;
   logic [7:0] port_b_level;
   logic [7:0] bus_level;
   logic [7:0] ram_rdata;
   logic       ram_wr_en;
   logic [7:0] int_rdata;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and internal RAM

   mbp_sync #(.W(16)) u_port_sync (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_pin     ({i_port_b_lines_in, i_port_a_lines_in}),
      .o_level   ({port_b_level, port_a_level})
   );

   mbp_sync #(.W(8)) u_bus_sync (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_pin     (i_muxed_address_data_lines_in),
      .o_level   (bus_level)
   );

   assign ram_wr_en = (st_reg.phase == PH_END) && st_reg.busy
                    && st_reg.wr && is_ram(st_reg.addr);

   mbp_ram #(.DEPTH(RAM_BYTES), .AW(RAM_AW)) u_ram (
      .i_clock   (i_clock),
      .i_wr_en   (ram_wr_en),
      .i_wr_addr (ram_index(st_reg.addr)),
      .i_wr_data (st_reg.wdata),
      .i_rd_addr (ram_index(st_reg.addr)),
      .o_rd_data (ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Internal read data

   always_comb
   begin
      int_rdata = 8'h00;
      if (is_ram(st_reg.addr))
         int_rdata = ram_rdata;
      else
         unique case (st_reg.addr)
            OFS_PORT_A:   int_rdata = (st_reg.dir_a & st_reg.lat_a)
                                    | (~st_reg.dir_a & port_a_level);
            OFS_PORT_B:   int_rdata = (st_reg.dir_b & st_reg.lat_b)
                                    | (~st_reg.dir_b & port_b_level);
            OFS_DIR_A:    int_rdata = st_reg.dir_a;
            OFS_DIR_B:    int_rdata = st_reg.dir_b;
            OFS_TMR_DATA: int_rdata = st_reg.tmr_data;
            OFS_TMR_CTRL: int_rdata = st_reg.tmr_ctrl;
            default:      int_rdata = 8'h00;
         endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      st_next           = st_reg;
      st_next.rsp_valid = 1'b0;
      // Five phases per bus cycle
      unique case (st_reg.phase)
         PH_ADDR: st_next.phase = PH_HOLD;
         PH_HOLD: st_next.phase = PH_DS1;
         PH_DS1:  st_next.phase = PH_DS2;
         PH_DS2:  st_next.phase = PH_END;
         PH_END:
         begin
            if (st_reg.busy)
            begin
               st_next.rsp_valid = 1'b1;
               if (!st_reg.wr)
                  st_next.rdata = is_internal(st_reg.addr) ?
                                  int_rdata : bus_level;
               else if (is_internal(st_reg.addr))
                  unique case (st_reg.addr)
                     OFS_PORT_A:   st_next.lat_a = st_reg.wdata;
                     OFS_PORT_B:   st_next.lat_b = st_reg.wdata;
                     OFS_DIR_A:    st_next.dir_a = st_reg.wdata;
                     OFS_DIR_B:    st_next.dir_b = st_reg.wdata;
                     OFS_TMR_DATA: st_next.tmr_data = st_reg.wdata;
                     OFS_TMR_CTRL: st_next.tmr_ctrl = st_reg.wdata;
                     default:      st_next.tmr_ctrl = st_reg.tmr_ctrl;
                  endcase
            end
            // No new cycle and no strobe in low power
            if (!i_low_power)
            begin
               st_next.phase = PH_ADDR;
               st_next.busy  = i_req_valid;
               if (i_req_valid)
               begin
                  st_next.wr    = i_req_write;
                  st_next.addr  = i_req_addr;
                  st_next.wdata = i_req_wdata;
               end
            end
            else
               st_next.busy = 1'b0;
         end
      endcase
      // Registered bus outputs follow the next phase
      st_next.as_q      = (st_next.phase == PH_ADDR);
      st_next.ds_q      = st_next.busy && (st_next.phase == PH_DS1
                       || st_next.phase == PH_DS2
                       || st_next.phase == PH_END);
      st_next.rw_q      = !(st_next.busy && st_next.wr);
      st_next.bus_drive = (st_next.phase == PH_ADDR)
                       || (st_next.busy && st_next.wr);
      st_next.bus_out   = (st_next.phase == PH_ADDR) ?
                          st_next.addr[7:0] : st_next.wdata;
      // Output lines show the latch while their direction bit is set
      st_next.pin_a     = st_next.lat_a & st_next.dir_a;
      st_next.pin_b     = st_next.lat_b & st_next.dir_b;
      // Stack pointer wraps inside its 64-byte window
      if (i_sp_reset)
         st_next.sp = SP_RESET;
      else if (i_sp_push && !i_sp_pop)
         st_next.sp = st_reg.sp - 6'h01;
      else if (i_sp_pop && !i_sp_push)
         st_next.sp = st_reg.sp + 6'h01;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         st_reg.phase     <= PH_END;
         st_reg.busy      <= 1'b0;
         st_reg.wr        <= 1'b0;
         st_reg.addr      <= '0;
         st_reg.wdata     <= 8'h00;
         st_reg.as_q      <= 1'b0;
         st_reg.ds_q      <= 1'b0;
         st_reg.rw_q      <= 1'b1;
         st_reg.bus_out   <= 8'h00;
         st_reg.bus_drive <= 1'b0;
         st_reg.dir_a     <= DIR_RESET;
         st_reg.dir_b     <= DIR_RESET;
         st_reg.pin_a     <= 8'h00;
         st_reg.pin_b     <= 8'h00;
         st_reg.tmr_data  <= TMR_RESET;
         st_reg.tmr_ctrl  <= TMR_RESET;
         st_reg.sp        <= SP_RESET;
         st_reg.rsp_valid <= 1'b0;
         st_reg.rdata     <= 8'h00;
         // Output latches keep their content across reset
         st_reg.lat_a     <= st_reg.lat_a;
         st_reg.lat_b     <= st_reg.lat_b;
      end
      else
         st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_req_ready = (st_reg.phase == PH_END) && !i_low_power;
   assign o_rsp_valid = st_reg.rsp_valid;
   assign o_rsp_rdata = st_reg.rdata;

   assign o_stack_addr = {SP_BASE, st_reg.sp};

   assign o_address_latch_strobe          = st_reg.as_q;
   assign o_data_transfer_strobe          = st_reg.ds_q;
   assign o_read_not_write                = st_reg.rw_q;
   assign o_upper_address_lines           = st_reg.addr[12:8];
   assign o_muxed_address_data_lines_out  = st_reg.bus_out;
   assign o_muxed_address_data_lines_oe_n = ~st_reg.bus_drive;

   assign o_port_a_lines_out  = st_reg.pin_a;
   assign o_port_a_lines_oe_n = ~st_reg.dir_a;
   assign o_port_b_lines_out  = st_reg.pin_b;
   assign o_port_b_lines_oe_n = ~st_reg.dir_b;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   sequence s_data_phase;
      !o_data_transfer_strobe ##1 o_data_transfer_strobe [*3];
   endsequence

   sequence s_cycle_end;
      ##1 o_address_latch_strobe || !o_data_transfer_strobe;
   endsequence

   property p_strobe_rate;
      o_address_latch_strobe ##4 !i_low_power |-> ##1 o_address_latch_strobe;
   endproperty
   a_strobe_rate: assert property (p_strobe_rate)
      else $error("address strobe not repeated after five clocks");

   property p_addr_on_bus;
      o_address_latch_strobe |-> !o_muxed_address_data_lines_oe_n
         && o_muxed_address_data_lines_out == st_reg.addr[7:0]
         ##1 !o_address_latch_strobe;
   endproperty
   a_addr_on_bus: assert property (p_addr_on_bus)
      else $error("low address not driven under address strobe");

   property p_transfer_strobe;
      o_address_latch_strobe && st_reg.busy |-> ##1 s_data_phase
         ##0 s_cycle_end;
   endproperty
   a_transfer_strobe: assert property (p_transfer_strobe)
      else $error("data strobe missing in a transfer cycle");

   property p_write_drives;
      o_data_transfer_strobe && !o_read_not_write
         |-> !o_muxed_address_data_lines_oe_n;
   endproperty
   a_write_drives: assert property (p_write_drives)
      else $error("bus not driven during write data phase");

   property p_read_releases;
      o_data_transfer_strobe && o_read_not_write
         |-> o_muxed_address_data_lines_oe_n;
   endproperty
   a_read_releases: assert property (p_read_releases)
      else $error("bus driven during read data phase");

   // Forward form avoids an unknown past value at the very first edge
   property p_dir_reset;
      disable iff (1'b0)
      i_sys_rst |=> o_port_a_lines_oe_n == 8'hff
         && o_port_b_lines_oe_n == 8'hff;
   endproperty
   a_dir_reset: assert property (p_dir_reset)
      else $error("port lines not inputs after reset");

   property p_upper_stable;
      o_address_latch_strobe |=> $stable(o_upper_address_lines) [*4];
   endproperty
   a_upper_stable: assert property (p_upper_stable)
      else $error("upper address moved inside a bus cycle");

   property p_stack_window;
      (o_stack_addr[12:6] == SP_BASE)
         and (i_sp_reset |=> o_stack_addr == 13'h007f);
   endproperty
   a_stack_window: assert property (p_stack_window)
      else $error("stack address outside its window");

   property p_port_write;
      o_rsp_valid && $past(st_reg.wr) && $past(st_reg.addr) == OFS_PORT_A
         |-> ((o_port_a_lines_out ^ $past(st_reg.wdata))
              & ~o_port_a_lines_oe_n) == 8'h00;
   endproperty
   a_port_write: assert property (p_port_write)
      else $error("written value not on output lines");

endmodule // mbp_top

// file: common/mbp_pkg.sv
package mbp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Address space
   localparam int          ADDR_W       = 13;
   localparam int          ADDR_SPACE   = 8192;
   localparam int          INT_LIMIT    = 128;
   localparam logic [12:0] OFS_PORT_A   = 13'h0000;
   localparam logic [12:0] OFS_PORT_B   = 13'h0001;
   localparam logic [12:0] OFS_DIR_A    = 13'h0004;
   localparam logic [12:0] OFS_DIR_B    = 13'h0005;
   localparam logic [12:0] OFS_TMR_DATA = 13'h0008;
   localparam logic [12:0] OFS_TMR_CTRL = 13'h0009;
   localparam logic [12:0] RAM_BASE     = 13'h0010;
   localparam int          RAM_BYTES    = 112;
   localparam int          RAM_AW       = 7;

   ////////////////////////////////////////////////////////////////////////
   // Stack window
   localparam int          STACK_BYTES  = 64;
   localparam logic [6:0]  SP_BASE      = 7'h01;
   localparam logic [5:0]  SP_RESET     = 6'h3f;

   ////////////////////////////////////////////////////////////////////////
   // Bus cycle: one phase per clock, oscillator divided by five
   localparam int          CLK_DIV      = 5;
   localparam logic [7:0]  DIR_RESET    = 8'h00;
   localparam logic [7:0]  TMR_RESET    = 8'h00;

   typedef enum logic [2:0] {
      PH_ADDR,
      PH_HOLD,
      PH_DS1,
      PH_DS2,
      PH_END
   } mbp_phase_t;

endpackage

// file: rtl/mbp_sync.sv
`timescale 1ns/1ps
module mbp_sync
   import mbp_pkg::*;
#(
   parameter int W = 8
)
(
   // Clock and reset
   input  wire logic         i_clock,
   input  wire logic         i_sys_rst,
   // Pin side
   input  wire logic [W-1:0] i_pin,
   // Filtered level
   output logic      [W-1:0] o_level
);

   if (W < 1) $error("mbp_sync: W must be at least 1");

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] held;
   } mbp_sync_t;

   mbp_sync_t st_reg;
   mbp_sync_t st_next;

   // A bit changes once stages two and three agree on it
   always_comb
   begin
      st_next      = st_reg;
      st_next.s1   = i_pin;
      st_next.s2   = st_reg.s1;
      st_next.s3   = st_reg.s2;
      st_next.held = (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3))
                   | (st_reg.held & (st_reg.s2 ^ st_reg.s3));
   end

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign o_level = st_next.held;

endmodule // mbp_sync

// file: rtl/mbp_ram.sv
`timescale 1ns/1ps
module mbp_ram
   import mbp_pkg::*;
#(
   parameter int DEPTH = RAM_BYTES,
   parameter int AW    = RAM_AW
)
(
   // Clock
   input  wire logic          i_clock,
   // Write port
   input  wire logic          i_wr_en,
   input  wire logic [AW-1:0] i_wr_addr,
   input  wire logic [7:0]    i_wr_data,
   // Read port
   input  wire logic [AW-1:0] i_rd_addr,
   output logic      [7:0]    o_rd_data
);

   if (DEPTH < 1 || DEPTH > (1 << AW))
      $error("mbp_ram: DEPTH does not fit the address width");

   logic [7:0] mem [DEPTH];

   always_ff @(posedge i_clock)
   begin
      if (i_wr_en)
         mem[i_wr_addr] <= i_wr_data;
      o_rd_data <= mem[i_rd_addr];
   end

endmodule // mbp_ram

// file: bench/mbp_ext_mem.sv
`timescale 1ns/1ps
module mbp_ext_mem
(
   // Clock
   input  wire logic       i_clock,
   // Device side of the bus
   input  wire logic       i_as,
   input  wire logic       i_ds,
   input  wire logic       i_rnw,
   input  wire logic [4:0] i_upper,
   input  wire logic [7:0] i_dev_out,
   input  wire logic       i_dev_oe_n,
   // Answer with inverted data
   input  wire logic       i_scramble,
   // Resolved bus level
   output logic      [7:0] o_level
);
   logic [7:0]  mem [8192];
   logic [12:0] addr_reg = 13'h0000;
   logic [2:0]  cnt_reg  = 3'h0;
   logic [7:0]  idle_reg = 8'h55;

   initial
   begin
      for (int i = 0; i < 8192; i++)
         mem[i] = 8'(i * 7);
   end

   always @(posedge i_clock)
   begin
      idle_reg <= ~idle_reg;
      if (i_as)
      begin
         addr_reg <= {i_upper, i_dev_out};
         cnt_reg  <= i_rnw ? 3'h4 : 3'h0;
      end
      else if (cnt_reg != 3'h0)
         cnt_reg <= cnt_reg - 3'h1;
      if (i_ds && !i_rnw)
         mem[addr_reg] <= i_dev_out;
   end

   // Read data stands from the clock after the strobe to the cycle end
   assign o_level = !i_dev_oe_n ? i_dev_out :
                    (cnt_reg != 3'h0) ? mem[addr_reg] ^ {8{i_scramble}} :
                    idle_reg;
endmodule // mbp_ext_mem

// file: bench/muxed_bus_io_ports_tb.sv
`timescale 1ns/1ps
module muxed_bus_io_ports_tb
   import mbp_pkg::*;
;
   logic        i_clock = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_write = 1'b0;
   logic        low_power = 1'b0;
   logic        sp_push = 1'b0;
   logic        sp_pop = 1'b0;
   logic        sp_rst = 1'b0;
   logic        scramble = 1'b0;
   logic [12:0] req_addr = 13'h0000;
   logic [7:0]  req_wdata = 8'h00;
   logic [7:0]  pa_drv = 8'h00;
   logic [7:0]  pb_drv = 8'h00;
   logic [7:0]  seed = 8'h3a;
   logic        rdy, rsp_v, as_s, ds_s, rnw, bus_oe_n;
   logic [7:0]  rdata, bus_out, bus_lvl, pa_out, pa_oe_n, pb_out, pb_oe_n;
   logic [4:0]  upper;
   logic [12:0] stack_addr;
   int          error_cnt = 0;
   int          checked = 0;
   int          ram_m [128];
   int          ext_m [int];
   int          dir_m [2];
   int          lat_m [2];
   int          tmr_m [2];
   wire  [7:0]  pa_pin = (pa_out & ~pa_oe_n) | (pa_drv & pa_oe_n);
   wire  [7:0]  pb_pin = (pb_out & ~pb_oe_n) | (pb_drv & pb_oe_n);

   mbp_top u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_req_valid(req_valid), .i_req_write(req_write),
      .i_req_addr(req_addr), .i_req_wdata(req_wdata), .o_req_ready(rdy),
      .o_rsp_valid(rsp_v), .o_rsp_rdata(rdata), .i_low_power(low_power),
      .i_sp_push(sp_push), .i_sp_pop(sp_pop), .i_sp_reset(sp_rst),
      .o_stack_addr(stack_addr), .o_address_latch_strobe(as_s),
      .o_data_transfer_strobe(ds_s), .o_read_not_write(rnw),
      .o_upper_address_lines(upper),
      .i_muxed_address_data_lines_in(bus_lvl),
      .o_muxed_address_data_lines_out(bus_out),
      .o_muxed_address_data_lines_oe_n(bus_oe_n),
      .i_port_a_lines_in(pa_pin), .o_port_a_lines_out(pa_out),
      .o_port_a_lines_oe_n(pa_oe_n), .i_port_b_lines_in(pb_pin),
      .o_port_b_lines_out(pb_out), .o_port_b_lines_oe_n(pb_oe_n));

   mbp_ext_mem u_ext (.i_clock(i_clock), .i_as(as_s), .i_ds(ds_s),
      .i_rnw(rnw), .i_upper(upper), .i_dev_out(bus_out),
      .i_dev_oe_n(bus_oe_n), .i_scramble(scramble), .o_level(bus_lvl));

   always #10 i_clock = ~i_clock;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string m);
      chk8({7'h00, got}, {7'h00, exp}, m);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask

   function automatic logic [7:0] rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction

   function automatic logic [7:0] exp_rd(input logic [12:0] a);
      int pin;
      pin = a[0] ? pb_drv : pa_drv;
      if (a < 13'h0002)
         return 8'((lat_m[a[0]] & dir_m[a[0]]) | (pin & ~dir_m[a[0]]));
      if (a == 13'h0004 || a == 13'h0005)
         return 8'(dir_m[a[0]]);
      if (a == 13'h0008 || a == 13'h0009)
         return 8'(tmr_m[a[0]]);
      if (a < 13'h0010)
         return 8'h00;
      if (a < 13'h0080)
         return 8'(ram_m[a]);
      return 8'(ext_m[a]);
   endfunction

   function automatic void mdl_wr(input logic [12:0] a, input logic [7:0] d);
      if (a < 13'h0002)
         lat_m[a[0]] = d;
      else if (a == 13'h0004 || a == 13'h0005)
         dir_m[a[0]] = d;
      else if (a == 13'h0008 || a == 13'h0009)
         tmr_m[a[0]] = d;
      else if (a >= 13'h0010 && a < 13'h0080)
         ram_m[a] = d;
      else if (a >= 13'h0080)
         ext_m[a] = d;
   endfunction

   task automatic bus(input logic wr, input logic [12:0] a,
                      input logic [7:0] d);
      int n;
      logic [7:0] e;
      n = 0;
      e = exp_rd(a);
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      while (rdy !== 1'b1 && n < 20)
      begin
         tick(1);
         n++;
      end
      chk1(rdy, 1'b1, "ready");
      tick(1);
      req_valid = 1'b0;
      for (int k = 1; k < 6; k++)
      begin
         chk8({3'h0, upper}, {3'h0, a[12:8]}, "upper");
         chk1(rnw, !wr, "rnw");
         chk1(as_s, k == 1, "as");
         chk1(ds_s, k > 2, "ds");
         chk1(bus_oe_n, k > 1 && !wr, "oe");
         if (k == 1)
            chk8(bus_out, a[7:0], "addr");
         else if (wr)
            chk8(bus_out, d, "wdata");
         tick(1);
      end
      chk1(rsp_v, 1'b1, "rsp");
      if (!wr)
         chk8(rdata, e, "rdata");
      else
         mdl_wr(a, d);
   endtask

   task automatic count_as(input int n, input int exp);
      int c;
      c = 0;
      repeat (n)
      begin
         c += (as_s === 1'b1);
         tick(1);
      end
      chk8(8'(c), 8'(exp), "as count");
   endtask

   task automatic conclude();
      if (error_cnt == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(20 * 20000);
      error_cnt++;
      conclude();
   end

   initial
   begin
      logic [7:0]  v;
      logic [7:0]  dir;
      logic [12:0] at [7];
      logic [12:0] ex [4];
      at = '{13'h0008, 13'h0009, 13'h0002, 13'h000f, 13'h0010, 13'h0040,
             13'h007f};
      ex = '{13'h0080, 13'h0100, 13'h0a5c, 13'h1fff};
      tick(6);
      i_sys_rst = 1'b0;
      chk8(pa_oe_n & pb_oe_n, 8'hff, "rst dir");
      chk1(stack_addr === 13'h007f, 1'b1, "sp");
      count_as(50, 10);
      for (int p = 0; p < 2; p++)
      begin
         v = rnd();
         bus(1'b1, 13'(p), v);
         bus(1'b1, 13'h0004 + 13'(p), 8'h00);
         bus(1'b1, 13'(p), ~v);
         chk8(p ? pb_oe_n : pa_oe_n, 8'hff, "in");
         dir = rnd();
         bus(1'b1, 13'h0004 + 13'(p), dir);
         chk8(p ? pb_oe_n : pa_oe_n, ~dir, "oe_n");
         chk8(p ? pb_out : pa_out, ~v & dir, "out");
         bus(1'b1, 13'(p), v);
         chk8(p ? pb_out : pa_out, v & dir, "out");
         pa_drv = rnd();
         pb_drv = rnd();
         tick(6);
         bus(1'b0, 13'(p), 8'h00);
         bus(1'b0, 13'h0004 + 13'(p), 8'h00);
      end
      i_sys_rst = 1'b1;
      tick(2);
      i_sys_rst = 1'b0;
      dir_m = '{0, 0};
      chk8(pa_oe_n & pb_oe_n, 8'hff, "rst dir");
      bus(1'b1, 13'h0004, 8'hff);
      chk8(pa_out, 8'(lat_m[0]), "kept latch");
      scramble = 1'b1;
      foreach (at[i])
         bus(1'b1, at[i], rnd());
      foreach (at[i])
         bus(1'b0, at[i], 8'h00);
      scramble = 1'b0;
      foreach (ex[i])
         bus(1'b1, ex[i], rnd());
      foreach (ex[i])
         bus(1'b0, ex[i], 8'h00);
      low_power = 1'b1;
      tick(10);
      chk1(rdy, 1'b0, "lp ready");
      count_as(20, 0);
      low_power = 1'b0;
      tick(10);
      count_as(50, 10);
      sp_push = 1'b1;
      tick(63);
      chk1(stack_addr === 13'h0040, 1'b1, "sp low");
      tick(1);
      chk1(stack_addr === 13'h007f, 1'b1, "sp wrap");
      sp_push = 1'b0;
      sp_pop = 1'b1;
      tick(1);
      chk1(stack_addr === 13'h0040, 1'b1, "sp pop");
      sp_pop = 1'b0;
      sp_rst = 1'b1;
      tick(1);
      sp_rst = 1'b0;
      chk1(stack_addr === 13'h007f, 1'b1, "sp rst");
      conclude();
   end
endmodule // muxed_bus_io_ports_tb
